// File: hw/nps_pkg.sv
// Package of constants for the NAND program, erase and protect sequencer.
`default_nettype none
package nps_pkg;
    // Command codes sent to the flash.
    localparam logic [7:0] CMD_SERIAL_IN   = 8'h80;
    localparam logic [7:0] CMD_PROG_CONF   = 8'h10;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
    localparam logic [7:0] CMD_ERASE_CONF  = 8'hD0;
    localparam logic [7:0] CMD_STATUS      = 8'h70;
    localparam logic [7:0] CMD_BLK_STATUS  = 8'h7A;
    localparam logic [7:0] CMD_RESET       = 8'hFF;
    localparam logic [7:0] CMD_READ1       = 8'h00;
    localparam logic [5:0] CMD_PROT_BASE   = 6'h10;
    // Operation codes written by software into the control register.
    localparam logic [2:0] OP_PROGRAM  = 3'h1;
    localparam logic [2:0] OP_ERASE    = 3'h2;
    localparam logic [2:0] OP_PROTECT  = 3'h3;
    localparam logic [2:0] OP_STATUS   = 3'h4;
    localparam logic [2:0] OP_BSTATUS  = 3'h5;
    localparam logic [2:0] OP_RESET    = 3'h6;
    localparam logic [2:0] OP_READ     = 3'h7;
    // Register byte offsets on the APB side.
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_DATA   = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_RDATA  = 8'h10;
    // Control register fields.
    localparam int CTRL_OP_LSB   = 0;
    localparam int CTRL_KIND_LSB = 4;
    localparam int CTRL_CNT_LSB  = 8;
    localparam int CTRL_SPARE    = 20;
    // Status register bit positions.
    localparam int ST_BUSY    = 0;
    localparam int ST_NEED    = 1;
    localparam int ST_RDY     = 2;
    localparam int ST_REFUSED = 3;
    localparam int ST_RVALID  = 4;
    // Flash geometry and protection limits.
    localparam int PAGE_BYTES     = 528;
    localparam int PAGES_PER_BLK  = 32;
    localparam int PROT_LAST_BLK  = 199;
    localparam int MAIN_PROG_MAX  = 1;
    localparam int SPARE_PROG_MAX = 2;
    // Strobe timing, in ns, and derived cycle counts at 100 MHz.
    localparam int CLK_PERIOD_NS  = 10;
    localparam int STROBE_LOW_NS  = 30;
    localparam int STROBE_HIGH_NS = 20;
    localparam int LOW_CYC  = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HIGH_CYC = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Time to wait after a command before watching ready/busy.
    localparam int WB_NS  = 100;
    localparam int WB_CYC = (WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : nps_pkg
`default_nettype wire

// File: hw/nps_cycle.sv
// One flash bus cycle: a command, address or data write, or a data read.
`default_nettype none
module nps_cycle (
    // Clock and reset.
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // Request from the sequencer.
    input  wire logic       i_go,
    input  wire logic       i_rd,
    input  wire logic       i_cle,
    input  wire logic       i_ale,
    input  wire logic [7:0] i_wdata,
    output logic            o_done,
    output logic [7:0]      o_rdata,
    // Flash strobes and data lanes.
    output logic            o_cle,
    output logic            o_ale,
    output logic            o_write_n,
    output logic            o_read_strobe_n,
    output logic [7:0]      o_io,
    output logic            o_io_oe,
    input  wire logic [7:0] i_io_sync
);
    typedef enum logic [1:0] {NPC_IDLE = 2'b00, NPC_LOW = 2'b01, NPC_HIGH = 2'b11} npc_st_t;
    npc_st_t  st_q;
    logic [3:0] cnt_q;

    // Strobe low phase then high recovery; read data is taken at the end of low.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_q            <= NPC_IDLE;
            cnt_q           <= 4'h0;
            o_cle           <= 1'b0;
            o_ale           <= 1'b0;
            o_write_n       <= 1'b1;
            o_read_strobe_n <= 1'b1;
            o_io            <= 8'h00;
            o_io_oe         <= 1'b0;
            o_rdata         <= 8'h00;
        end else begin
            unique case (st_q)
                NPC_IDLE: begin
                    if (i_go) begin
                        st_q            <= NPC_LOW;
                        cnt_q           <= 4'(nps_pkg::LOW_CYC - 1);
                        o_cle           <= i_cle;
                        o_ale           <= i_ale;
                        o_io            <= i_wdata;
                        o_io_oe         <= !i_rd;
                        o_write_n       <= i_rd;
                        o_read_strobe_n <= !i_rd;
                    end
                end
                NPC_LOW: begin
                    if (cnt_q == 4'h0) begin
                        st_q            <= NPC_HIGH;
                        cnt_q           <= 4'(nps_pkg::HIGH_CYC - 1);
                        o_write_n       <= 1'b1;
                        o_read_strobe_n <= 1'b1;
                        // Synchroniser adds two cycles; low phase covers the access time.
                        o_rdata         <= i_io_sync;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                NPC_HIGH: begin
                    if (cnt_q == 4'h0) begin
                        st_q    <= NPC_IDLE;
                        o_io_oe <= 1'b0;
                        o_cle   <= 1'b0;
                        o_ale   <= 1'b0;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                default: st_q <= NPC_IDLE;
            endcase
        end
    end

    assign o_done = (st_q == NPC_HIGH) && (cnt_q == 4'h0);
endmodule : nps_cycle
`default_nettype wire

// File: hw/nps_host.sv
// Host-side sequencer that drives a small-page NAND flash for program, erase and protect.
// Summary of operation
// - Sequential reads stop at block end, chip enable high.
// - Crossing block needs new read command and address.
// - One main, two spare partial programs per erase; counted per page index across all blocks, and any erase clears them.
// - Program is 80h, four addresses, then data.
// - During program only status and reset commands.
// - Erase is 60h plus three block addresses.
// - Protect is 4xh, 80h, four zero-low addresses, 10h.
// - Protect only blocks up to 200th, never twice; a repeat protect is not refused here.
//
// The placing of the registers and the APB slave port were left to the implementer.
`default_nettype none
module nps_host #(
    parameter int ROW_W = 17
) (
    // Clock and reset.
    input  wire logic        I_CORE_CLK,
    input  wire logic        I_RST,
    // APB slave.
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [7:0]  I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output logic [31:0]      O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    // Flash pins.
    output logic             O_CE_N,
    output logic             O_CLE,
    output logic             O_ALE,
    output logic             O_WRITE_N,
    output logic             O_READ_STROBE_N,
    output logic             O_WP_N,
    output logic [7:0]       O_IO,
    output logic             O_IO_OE,
    input  wire logic [7:0]  I_IO,
    input  wire logic        I_READY_BUSY_N
);
    // The block field needs eight bits and the row must fit the 32-bit address word.
    if (ROW_W < 13 || ROW_W > 23) begin : g_row_check
        $error("ROW_W out of range");
    end

    typedef enum logic [3:0] {
        NPS_IDLE = 4'b0000, NPS_CMD0 = 4'b0001, NPS_CMD1 = 4'b0011, NPS_ADDR = 4'b0010,
        NPS_DATA = 4'b0110, NPS_CONF = 4'b0111, NPS_WAIT = 4'b0101, NPS_BUSY = 4'b0100,
        NPS_STAT = 4'b1100, NPS_SREAD = 4'b1101, NPS_DREAD = 4'b1111
    } nps_st_t;

    nps_st_t     st_q;
    logic [31:0] ctrl_q;
    logic [31:0] addr_q;
    logic [7:0]  wdata_q;
    logic        wfull_q;
    logic [7:0]  rdata_q;
    logic        rvalid_q;
    logic        refused_q;
    logic [1:0]  acnt_q;
    logic [9:0]  dcnt_q;
    logic [7:0]  wait_q;
    logic [1:0]  rb_sync_q;
    logic [7:0]  io_s1_q;
    logic [7:0]  io_s2_q;
    localparam int PAGES_PER = nps_pkg::PAGES_PER_BLK;
    // Per page: bit 0 marks the main area used, bits 2:1 count spare programs.
    logic [2:0]  part_q [PAGES_PER];

    // Cycle engine request.
    logic       cy_go;
    logic       cy_rd;
    logic       cy_cle;
    logic       cy_ale;
    logic [7:0] cy_wd;
    logic       cy_done;
    logic [7:0] cy_rdata;

    logic [2:0] op;
    logic       apb_wr;
    logic       rb_ready;
    assign op       = ctrl_q[nps_pkg::CTRL_OP_LSB +: 3];
    assign apb_wr   = I_PSEL && I_PENABLE && I_PWRITE;
    assign rb_ready = rb_sync_q[1];

    // Pin inputs pass two flops; only the second stage is read.
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            rb_sync_q <= 2'b00;
            io_s1_q   <= 8'h00;
            io_s2_q   <= 8'h00;
        end else begin
            rb_sync_q <= {rb_sync_q[0], I_READY_BUSY_N};
            io_s1_q   <= I_IO;
            io_s2_q   <= io_s1_q;
        end
    end

    // Address byte for the current cycle; erase skips the column byte.
    function automatic logic [7:0] addr_byte(input logic [31:0] a, input logic [1:0] i,
                                             input logic ers);
        logic [1:0] k;
        k = ers ? i + 2'd1 : i;
        unique case (k)
            2'd0:    addr_byte = a[7:0];
            2'd1:    addr_byte = a[16:9];
            2'd2:    addr_byte = a[24:17];
            default: addr_byte = {7'h00, a[25]};
        endcase
    endfunction : addr_byte

    logic is_ers;
    logic is_prot;
    logic [ROW_W-1:0] row;
    assign is_ers  = (op == nps_pkg::OP_ERASE);
    assign is_prot = (op == nps_pkg::OP_PROTECT);
    assign row     = addr_q[9 +: ROW_W];

    // Drive the cycle engine from the current state.
    always_comb begin
        cy_go  = 1'b0;
        cy_rd  = 1'b0;
        cy_cle = 1'b0;
        cy_ale = 1'b0;
        cy_wd  = 8'h00;
        unique case (st_q)
            NPS_CMD0: begin
                cy_go  = 1'b1;
                cy_cle = 1'b1;
                unique case (op)
                    nps_pkg::OP_PROGRAM: cy_wd = nps_pkg::CMD_SERIAL_IN;
                    nps_pkg::OP_ERASE:   cy_wd = nps_pkg::CMD_ERASE_SETUP;
                    nps_pkg::OP_PROTECT: cy_wd = {nps_pkg::CMD_PROT_BASE,
                                                  ctrl_q[nps_pkg::CTRL_KIND_LSB +: 2]};
                    nps_pkg::OP_STATUS:  cy_wd = nps_pkg::CMD_STATUS;
                    nps_pkg::OP_BSTATUS: cy_wd = nps_pkg::CMD_BLK_STATUS;
                    nps_pkg::OP_RESET:   cy_wd = nps_pkg::CMD_RESET;
                    default:             cy_wd = nps_pkg::CMD_READ1;
                endcase
            end
            NPS_CMD1: begin
                cy_go  = 1'b1;
                cy_cle = 1'b1;
                cy_wd  = nps_pkg::CMD_SERIAL_IN;
            end
            NPS_ADDR: begin
                cy_go  = 1'b1;
                cy_ale = 1'b1;
                // Protect forces the low address bits to zero; erase drops A9-A13.
                cy_wd  = is_prot ? addr_byte({addr_q[31:14], 14'h0000}, acnt_q, 1'b0)
                       : is_ers ? addr_byte({addr_q[31:14], 14'h0000}, acnt_q, 1'b1)
                       : addr_byte(addr_q, acnt_q, 1'b0);
            end
            NPS_DATA: begin
                cy_go = wfull_q;
                cy_wd = wdata_q;
            end
            NPS_CONF: begin
                cy_go  = 1'b1;
                cy_cle = 1'b1;
                cy_wd  = is_ers ? nps_pkg::CMD_ERASE_CONF : nps_pkg::CMD_PROG_CONF;
            end
            NPS_STAT: begin
                cy_go  = 1'b1;
                cy_cle = 1'b1;
                cy_wd  = nps_pkg::CMD_STATUS;
            end
            NPS_SREAD, NPS_DREAD: begin
                cy_go = 1'b1;
                cy_rd = 1'b1;
            end
            default: ;
        endcase
    end

    logic [9:0]  dmax;
    logic [2:0]  pidx;
    logic        bad_req;
    assign dmax = ctrl_q[nps_pkg::CTRL_CNT_LSB +: 10];
    assign pidx = part_q[addr_q[13:9]];
    // Refuse partial-page programs past the limit, empty programs, bad protect blocks.
    assign bad_req = (op == nps_pkg::OP_PROGRAM &&
                      (dmax == 10'h000 || dmax > 10'(nps_pkg::PAGE_BYTES) ||
                       (ctrl_q[nps_pkg::CTRL_SPARE]
                        ? pidx[2:1] >= 2'(nps_pkg::SPARE_PROG_MAX) : pidx[0]))) ||
                     (is_prot && row[ROW_W-1:5] > (ROW_W-5)'(nps_pkg::PROT_LAST_BLK));

    // Sequencer state.
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            st_q      <= NPS_IDLE;
            acnt_q    <= 2'd0;
            dcnt_q    <= 10'h000;
            wait_q    <= 8'h00;
            rvalid_q  <= 1'b0;
            refused_q <= 1'b0;
            rdata_q   <= 8'h00;
            O_CE_N    <= 1'b1;
        end else begin
            unique case (st_q)
                NPS_IDLE: begin
                    if (apb_wr && I_PADDR == nps_pkg::REG_CTRL) begin
                        refused_q <= 1'b0;
                        O_CE_N    <= 1'b0;
                        st_q      <= NPS_CMD0;
                    end
                end
                NPS_CMD0: if (cy_done) begin
                    if (bad_req) begin
                        st_q      <= NPS_IDLE;
                        refused_q <= 1'b1;
                        O_CE_N    <= 1'b1;
                    end else if (is_prot) begin
                        st_q <= NPS_CMD1;
                    end else if (op == nps_pkg::OP_RESET) begin
                        st_q   <= NPS_WAIT;
                        wait_q <= 8'(nps_pkg::WB_CYC);
                    end else if (op == nps_pkg::OP_STATUS || op == nps_pkg::OP_BSTATUS) begin
                        st_q <= NPS_SREAD;
                    end else begin
                        st_q   <= NPS_ADDR;
                        acnt_q <= 2'd0;
                    end
                end
                NPS_CMD1: if (cy_done) begin
                    st_q   <= NPS_ADDR;
                    acnt_q <= 2'd0;
                end
                NPS_ADDR: if (cy_done) begin
                    acnt_q <= acnt_q + 2'd1;
                    if (acnt_q == (is_ers ? 2'd2 : 2'd3)) begin
                        dcnt_q <= 10'h000;
                        st_q   <= is_ers || is_prot ? NPS_CONF
                                : op == nps_pkg::OP_READ ? NPS_WAIT : NPS_DATA;
                        wait_q <= 8'(nps_pkg::WB_CYC);
                    end
                end
                NPS_DATA: if (cy_done) begin
                    dcnt_q <= dcnt_q + 10'h001;
                    if (dcnt_q + 10'h001 == dmax) st_q <= NPS_CONF;
                end
                NPS_CONF: if (cy_done) begin
                    st_q   <= NPS_WAIT;
                    wait_q <= 8'(nps_pkg::WB_CYC);
                end
                NPS_WAIT: begin
                    if (wait_q == 8'h00) st_q <= NPS_BUSY;
                    else wait_q <= wait_q - 8'h01;
                end
                NPS_BUSY: if (rb_ready) begin
                    // A read goes on to the data read and a reset to idle; every other operation reads status.
                    st_q <= op == nps_pkg::OP_READ ? NPS_DREAD
                          : op == nps_pkg::OP_RESET ? NPS_IDLE : NPS_STAT;
                    if (op == nps_pkg::OP_RESET) O_CE_N <= 1'b1;
                end
                NPS_STAT: if (cy_done) st_q <= NPS_SREAD;
                NPS_SREAD: if (cy_done) begin
                    rdata_q  <= cy_rdata;
                    rvalid_q <= 1'b1;
                    st_q     <= NPS_IDLE;
                    O_CE_N   <= 1'b1;
                end
                NPS_DREAD: if (cy_done) begin
                    rdata_q  <= cy_rdata;
                    rvalid_q <= 1'b1;
                    st_q     <= NPS_IDLE;
                    O_CE_N   <= 1'b1;
                end
                default: st_q <= NPS_IDLE;
            endcase
            if (!apb_wr && I_PSEL && I_PENABLE && I_PADDR == nps_pkg::REG_RDATA
                && st_q != NPS_SREAD && st_q != NPS_DREAD) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // Partial-program bookkeeping per page index, shared by every block; any erase clears it all.
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            for (int i = 0; i < PAGES_PER; i++) part_q[i] <= 3'b000;
        end else if (st_q == NPS_CONF && cy_done) begin
            if (is_ers) begin
                for (int i = 0; i < PAGES_PER; i++) part_q[i] <= 3'b000;
            end else if (op == nps_pkg::OP_PROGRAM) begin
                if (ctrl_q[nps_pkg::CTRL_SPARE]) part_q[addr_q[13:9]][2:1] <= pidx[2:1] + 2'd1;
                else part_q[addr_q[13:9]][0] <= 1'b1;
            end
        end
    end

    // Software registers; writes are taken only at the access edge.
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            ctrl_q  <= 32'h0000_0000;
            addr_q  <= 32'h0000_0000;
            wdata_q <= 8'h00;
            wfull_q <= 1'b0;
        end else begin
            if (apb_wr && st_q == NPS_IDLE && I_PADDR == nps_pkg::REG_CTRL) ctrl_q <= I_PWDATA;
            if (apb_wr && st_q == NPS_IDLE && I_PADDR == nps_pkg::REG_ADDR) addr_q <= I_PWDATA;
            if (apb_wr && I_PADDR == nps_pkg::REG_DATA && !wfull_q) begin
                wdata_q <= I_PWDATA[7:0];
                wfull_q <= 1'b1;
            end else if ((st_q == NPS_DATA && cy_done) ||
                         (apb_wr && st_q == NPS_IDLE && I_PADDR == nps_pkg::REG_CTRL)) begin
                // A new operation drops any byte left behind by a refused program.
                wfull_q <= 1'b0;
            end
        end
    end

    logic need;
    assign need      = (st_q == NPS_DATA) && !wfull_q;
    // Data writes stall while the byte holder is full; other accesses answer at once.
    assign O_PREADY  = !(I_PWRITE && I_PADDR == nps_pkg::REG_DATA && wfull_q);
    assign O_PSLVERR = I_PSEL && I_PENABLE && I_PADDR > nps_pkg::REG_RDATA;
    assign O_WP_N    = 1'b1;

    // Read data mux, registered so it is a flop output.
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            O_PRDATA <= 32'h0000_0000;
        end else if (I_PSEL && !I_PENABLE) begin
            unique case (I_PADDR)
                nps_pkg::REG_CTRL:   O_PRDATA <= ctrl_q;
                nps_pkg::REG_ADDR:   O_PRDATA <= addr_q;
                nps_pkg::REG_STATUS: O_PRDATA <= {27'h0, rvalid_q, refused_q, rb_ready, need,
                                                  st_q != NPS_IDLE};
                nps_pkg::REG_RDATA:  O_PRDATA <= {24'h0, rdata_q};
                default:             O_PRDATA <= 32'h0000_0000;
            endcase
        end
    end

    nps_cycle u_cycle (
        .i_clk           (I_CORE_CLK),
        .i_rst           (I_RST),
        .i_go            (cy_go),
        .i_rd            (cy_rd),
        .i_cle           (cy_cle),
        .i_ale           (cy_ale),
        .i_wdata         (cy_wd),
        .o_done          (cy_done),
        .o_rdata         (cy_rdata),
        .o_cle           (O_CLE),
        .o_ale           (O_ALE),
        .o_write_n       (O_WRITE_N),
        .o_read_strobe_n (O_READ_STROBE_N),
        .o_io            (O_IO),
        .o_io_oe         (O_IO_OE),
        .i_io_sync       (io_s2_q)
    );

    // Protect never loads data bytes.
    no_prot_data_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        is_prot |-> st_q != NPS_DATA) else $error("data loaded during protect");
    // A refused request never reaches the confirm cycle.
    refuse_stop_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        (st_q == NPS_CMD0 && cy_done && bad_req) |=> st_q == NPS_IDLE && refused_q)
        else $error("bad request went on");
    // After a program confirm the next command sent is status.
    stat_after_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        (st_q == NPS_BUSY && rb_ready && op == nps_pkg::OP_PROGRAM) |=> st_q == NPS_STAT)
        else $error("status not read after program");
    // Erase address cycles never carry A9 to A13.
    erase_addr_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        (st_q == NPS_ADDR && is_ers && acnt_q == 2'd0) |-> cy_wd[4:0] == 5'h00)
        else $error("erase address low bits set");
    // A plain read ends with chip enable released.
    read_end_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        (st_q == NPS_DREAD && cy_done) |=> O_CE_N)
        else $error("chip enable held after read");
    // The main area of a page is confirmed at most once per erase.
    main_once_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        (st_q == NPS_CONF && cy_done && op == nps_pkg::OP_PROGRAM
         && !ctrl_q[nps_pkg::CTRL_SPARE]) |-> !pidx[0])
        else $error("main area programmed twice");
    // The spare area of a page is confirmed at most twice per erase.
    spare_limit_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        (st_q == NPS_CONF && cy_done && op == nps_pkg::OP_PROGRAM
         && ctrl_q[nps_pkg::CTRL_SPARE]) |-> pidx[2:1] < 2'(nps_pkg::SPARE_PROG_MAX))
        else $error("spare area programmed too often");
endmodule : nps_host
`default_nettype wire

// File: bench/nps_flash_model.sv
// Behavioural flash device that answers the sequencer's strobes.
`default_nettype none
module nps_flash_model (
    // Strobes and data from the host.
    input  wire logic       i_ce_n,
    input  wire logic       i_cle,
    input  wire logic       i_ale,
    input  wire logic       i_write_n,
    input  wire logic       i_read_strobe_n,
    input  wire logic [7:0] i_io,
    // Answers to the host.
    output logic [7:0]      o_io,
    output logic            o_ready_busy_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0]  cmd_q = 8'h00;
    logic [7:0]  kind_q = 8'h00;
    logic [31:0] adr_q = 32'h0;
    logic [1:0]  prot_q [0:255] = '{default: 2'h0};
    int          nd_q = 0;
    realtime     end_q = 0;
    // Address bytes shift in from the top, so three or four cycles leave the row alike.
    wire logic [7:0] blk = adr_q[20:13];
    // Everything is latched on the rising write strobe; busy is kept as an end time.
    always @(posedge i_write_n) begin
        if (!i_ce_n && i_cle) begin
            if (i_io == 8'h10 && kind_q != 8'h00) begin
                prot_q[blk] = prot_q[blk] | kind_q[1:0];
                end_q = $realtime + 2000;
            end else if (i_io == 8'h10 && nd_q > 0) begin
                end_q = $realtime + (prot_q[blk][0] ? 500 : 2000);
            end else if (i_io == 8'hD0) begin
                end_q = $realtime + (prot_q[blk][1] ? 500 : 3000);
                if (!prot_q[blk][1])
                    prot_q[blk] = 2'h0;
            end else if (i_io == 8'hFF) begin
                end_q = $realtime + 100;
            end
            kind_q = (i_io[7:4] == 4'h4) ? i_io : ((i_io == 8'h80) ? kind_q : 8'h00);
            nd_q = 0;
            cmd_q = i_io;
        end else if (!i_ce_n && i_ale) begin
            adr_q = {i_io, adr_q[31:8]};
        end else if (!i_ce_n && nd_q < 528) begin
            nd_q = nd_q + 1;
        end
    end
    // Status leaves on the falling read strobe; after hold the lanes flip so stale data shows.
    always @(negedge i_read_strobe_n) begin
        if (!i_ce_n)
            o_io = (cmd_q == 8'h7A) ? {1'b1, o_ready_busy_n, 4'h0, prot_q[blk]}
                                    : {1'b1, o_ready_busy_n, 6'h00};
    end
    always @(posedge i_read_strobe_n) begin
        o_io <= #5 ~o_io;
    end
    // Ready follows the end time of the current internal operation.
    initial begin
        o_io = 8'h00;
        o_ready_busy_n = 1'b1;
        forever #5 o_ready_busy_n = ($realtime >= end_q);
    end
endmodule : nps_flash_model
`default_nettype wire

// File: bench/nps_host_tb.sv
// Testbench that drives the sequencer over APB against the flash model.
`default_nettype none
module nps_host_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst, psel, pen, pwr, pready, err, ce_n, cle, ale, we_n, re_n, rb_n;
    logic        wp_n, perr;
    logic [7:0]  paddr, io_o, io_i;
    logic [31:0] pwdata, prdata, r, st, rd;
    int          miscompares = 0;
    int          n_tests = 0;
    nps_host u_nps_host (.I_CORE_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(err), .O_CE_N(ce_n), .O_CLE(cle), .O_ALE(ale),
        .O_WRITE_N(we_n), .O_READ_STROBE_N(re_n), .O_WP_N(wp_n), .O_IO(io_o), .O_IO_OE(),
        .I_IO(io_i), .I_READY_BUSY_N(rb_n));
    nps_flash_model u_nps_flash_model (.i_ce_n(ce_n), .i_cle(cle), .i_ale(ale),
        .i_write_n(we_n), .i_read_strobe_n(re_n), .i_io(io_o), .o_io(io_i),
        .o_ready_busy_n(rb_n));
    // One APB transfer; the request is held until pready is seen high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, pen, pwr, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        perr = err;
        {psel, pen} <= 2'b00;
    endtask : apb
    // One operation: address, control, data bytes, poll until idle, fetch result.
    task automatic run(input logic [31:0] a, input logic [31:0] c, input int n);
        apb(1'b1, 8'h04, a);
        apb(1'b1, 8'h00, c);
        for (int i = 0; i < n; i++)
            apb(1'b1, 8'h08, 32'(i + 8'h5A));
        do apb(1'b0, 8'h0C, 32'h0); while (r[0] !== 1'b0);
        st = r;
        rd = 32'hFFFF_FFFF;
        if (st[4] === 1'b1) begin
            apb(1'b0, 8'h10, 32'h0);
            rd = r;
        end
        $display("Test with control %0h finished, status %0h", c, st[7:0]);
    endtask : run
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %0h, expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Cut a hang short well past the longest expected run.
    initial begin
        #500_000;
        miscompares++;
        conclude();
    end
    // Main sequence of operations with expected results.
    initial begin
        {rst, psel, pen, pwr, paddr, pwdata} = {1'b1, 43'h0};
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        run(32'h0001_4000, 32'h0000_0301, 3);
        chk(rd[7:0], 8'hC0);
        run(32'h0001_4000, 32'h0000_0101, 1);
        chk(st[7:0] & 8'h09, 8'h08);
        run(32'h0002_8000, 32'h0000_0001, 0);
        chk(st[7:0] & 8'h09, 8'h08);
        run(32'h0002_8000, 32'h0002_1101, 0);
        chk(st[7:0] & 8'h09, 8'h08);
        for (int j = 0; j < 3; j++) begin
            run(32'h0001_4000, 32'h0010_0101, 1);
            chk(st[7:0] & 8'h09, (j < 2) ? 8'h00 : 8'h08);
        end
        run(32'h0001_4000, 32'h0000_0013, 0);
        chk(rd[7:0], 8'hC0);
        run(32'h0001_4000, 32'h0000_0005, 0);
        chk(rd[7:0], 8'hC1);
        run(32'h0001_4000, 32'h0000_0002, 0);
        chk(rd[7:0], 8'hC0);
        run(32'h0001_4000, 32'h0000_0005, 0);
        chk(rd[7:0], 8'hC0);
        for (int k = 2; k < 4; k++) begin
            run(32'((k + 4) << 14), 32'(8'h03 | (k << 4)), 0);
            run(32'h0, 32'h0000_0005, 0);
            chk(rd[7:0], 8'(8'hC0 | k));
        end
        run(32'h0001_8000, 32'h0000_0002, 0);
        run(32'h0, 32'h0000_0005, 0);
        chk(rd[7:0], 8'hC2);
        run(32'h0001_4000, 32'h0000_0007, 0);
        chk(rd[7:0], 8'hC0);
        run(32'h0032_0000, 32'h0000_0013, 0);
        chk(st[7:0] & 8'h09, 8'h08);
        run(32'h0, 32'h0000_0004, 0);
        chk(rd[7:0], 8'hC0);
        run(32'h0, 32'h0000_0006, 0);
        chk(st[7:0] & 8'h01, 8'h00);
        apb(1'b0, 8'h14, 32'h0);
        chk({7'h0, perr}, 8'h01);
        chk({7'h0, wp_n}, 8'h01);
        conclude();
    end
endmodule : nps_host_tb
`default_nettype wire
